// file: logic/dlurc_ctrl.sv
// dual-channel dac double-buffer, load strobe, mask, reset and reference control
//
// Summary of operation
// RULE1 - a frame counts only with exactly 24 serial clocks, latched as sync rises
// RULE2 - the command sits in the top four frame bits, above four address bits
// RULE3 - input write with strobe low updates input and dac register at once
// RULE4 - input write with strobe high changes input only; strobe fall updates dacs
// RULE5 - update command copies selected inputs to dac registers, inputs unchanged
// RULE6 - write-and-update command loads input and dac register of addressed channel
// RULE7 - mask command loads the four-bit load mask from the low four bits
// RULE8 - load mask bits reset to zero so channels follow the strobe
// RULE9 - a masked channel ignores the strobe as if it were held high
// RULE10 - mask bit three steers channel b, bit zero channel a
// RULE11 - each strobe falling edge copies input to dac on unmasked channels
// RULE12 - with strobe tied low the mask is ignored and writes update at once
// RULE13 - hardware reset clears outputs to zero or midscale by the select pin
// RULE14 - no updates during hardware reset; cleared value holds afterwards
// RULE15 - soft reset command acts like the hardware reset
// RULE16 - strobe activity during power-on reset is ignored
// RULE17 - reset pin low at power-up keeps the device waiting until release
// RULE18 - power-on code is zero scale with select low, midscale with it high
// RULE19 - outputs hold the power-on level until the first valid write
// RULE20 - reference command loads bit zero; zero keeps reference on, one off
// RULE21 - data shifts on serial clock falling edges, decoded when sync rises
module dlurc_ctrl #(
    parameter int unsigned DATA_W = 10
) (
    input  wire logic              i_clk,
    input  wire logic              i_rstn,
    input  wire logic              i_sclk,
    input  wire logic              i_sync_n,
    input  wire logic              i_serial_in,
    input  wire logic              i_load_strobe_n,
    input  wire logic              i_reset_n,
    input  wire logic              i_reset_level_select,
    output logic [DATA_W-1:0]      o_dac_a,
    output logic [DATA_W-1:0]      o_dac_b,
    output logic [DATA_W-1:0]      o_input_a,
    output logic [DATA_W-1:0]      o_input_b,
    output logic [3:0]             o_load_mask,
    output logic                   o_reference_off,
    output logic                   o_init_done,
    output logic                   o_frame_reject
);

    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (DATA_W < 2 || DATA_W > 16) begin : g_bad_width
        $error("dlurc_ctrl: DATA_W must lie between 2 and 16");
    end

    localparam int unsigned NCH = dlurc_pkg::CHANNELS;
    localparam logic [DATA_W-1:0] ZERO_CODE = '0;
    localparam logic [DATA_W-1:0] MID_CODE  = {1'b1, {(DATA_W-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////
    // declarations
    logic [dlurc_pkg::FRAME_BITS-1:0] shift_w;
    logic [dlurc_pkg::CNT_W-1:0]      count_w;
    logic [3:0]                       pin_lvl;
    logic                             sync_lvl;
    logic                             strobe_lvl;
    logic                             rst_pin_lvl;
    logic                             sel_lvl;
    logic                             sync_prev_r;
    logic                             strobe_prev_r;
    logic                             strobe_seen_high_r;
    dlurc_pkg::dlurc_state_e          state_r;
    dlurc_pkg::dlurc_state_e          state_nxt;
    dlurc_pkg::dlurc_frame_s          frame;
    logic                             frame_end;
    logic                             frame_ok;
    logic                             run;
    logic                             take;
    logic                             strobe_fall;
    logic                             tied_low;
    logic [DATA_W-1:0]                por_code;
    logic [DATA_W-1:0]                new_code;
    logic [DATA_W-1:0]                in_r  [NCH];
    logic [DATA_W-1:0]                dac_r [NCH];
    logic [3:0]                       mask_r;
    logic                             ref_r;
    logic                             init_done_r;
    logic                             reject_r;
    logic [NCH-1:0]                   sel;
    logic [NCH-1:0]                   mask_ch;

    ////////////////////////////////////////////////////////////////////////
    // serial link side on its own clock
    dlurc_frame_rx u_rx (
        .i_sclk      (i_sclk),
        .i_rstn      (i_rstn),
        .i_sync_n    (i_sync_n),
        .i_serial_in (i_serial_in),
        .o_shift     (shift_w),
        .o_count     (count_w)
    );

    // the four control pins are asynchronous to i_clk, so all pass the three-stage chain
    dlurc_sync3 #(
        .W       (4),
        .RST_VAL (4'h3)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_async ({i_reset_level_select, i_reset_n, i_load_strobe_n, i_sync_n}),
        .o_level (pin_lvl)
    );

    assign sync_lvl    = pin_lvl[0];
    assign strobe_lvl  = pin_lvl[1];
    assign rst_pin_lvl = pin_lvl[2];
    assign sel_lvl     = pin_lvl[3];

    ////////////////////////////////////////////////////////////////////////
    // edge history of the settled pin levels
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_prev_r   <= 1'b1;
            strobe_prev_r <= 1'b1;
        end else begin
            sync_prev_r   <= sync_lvl;
            strobe_prev_r <= strobe_lvl;
        end
    end

    // a strobe never seen high while running counts as tied low; gating with run
    // keeps the idle-high reset value of the sync chain from counting as a high
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            strobe_seen_high_r <= 1'b0;
        end else if (strobe_lvl && run) begin                         // RULE12
            strobe_seen_high_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame decode; the shift word is quiet while sync is high, so it is
    // safe to read a few cycles after the settled sync rise
    assign frame       = dlurc_pkg::dlurc_frame_s'(shift_w);
    assign frame_end   = sync_lvl & ~sync_prev_r;                    // RULE21
    assign frame_ok    = (count_w == dlurc_pkg::FRAME_LEN);          // RULE1
    assign run         = (state_r == dlurc_pkg::ST_RUN);
    assign take        = frame_end & frame_ok & run;
    assign strobe_fall = ~strobe_lvl & strobe_prev_r & run;          // RULE16
    assign tied_low    = ~strobe_seen_high_r;
    assign por_code    = sel_lvl ? MID_CODE : ZERO_CODE;             // RULE18
    assign new_code    = frame.payload[dlurc_pkg::PAY_MSB -: DATA_W];

    // address and mask bit per channel
    assign sel[0]     = frame.addr[dlurc_pkg::ADDR_A_BIT];
    assign sel[1]     = frame.addr[dlurc_pkg::ADDR_B_BIT];
    assign mask_ch[0] = mask_r[dlurc_pkg::MASK_A_BIT] & ~tied_low;   // RULE10 RULE12
    assign mask_ch[1] = mask_r[dlurc_pkg::MASK_B_BIT] & ~tied_low;   // RULE10 RULE12

    ////////////////////////////////////////////////////////////////////////
    // reset sequencing: wait on the reset pin, clear on soft reset
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            dlurc_pkg::ST_WAIT: begin
                if (rst_pin_lvl) begin
                    state_nxt = dlurc_pkg::ST_RUN;                   // RULE17
                end
            end
            dlurc_pkg::ST_CLEAR: begin
                state_nxt = rst_pin_lvl ? dlurc_pkg::ST_RUN : dlurc_pkg::ST_WAIT;
            end
            dlurc_pkg::ST_RUN: begin
                if (!rst_pin_lvl) begin
                    state_nxt = dlurc_pkg::ST_WAIT;                  // RULE13
                end else if (take && frame.cmd == dlurc_pkg::CMD_SOFT_RST) begin
                    state_nxt = dlurc_pkg::ST_CLEAR;                 // RULE15
                end
            end
            default: begin
                state_nxt = dlurc_pkg::ST_WAIT;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_r <= dlurc_pkg::ST_WAIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per channel double buffer; outside run the registers are forced to the
    // power-on code, which both clears them and blocks every update
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic wr_in;
            logic now_upd;
            logic copy;

            assign wr_in   = take & sel[ch] & (frame.cmd == dlurc_pkg::CMD_WRITE_IN ||
                                               frame.cmd == dlurc_pkg::CMD_WRITE_UPD);
            // immediate dac load with the frame data
            assign now_upd = take & sel[ch] & ((frame.cmd == dlurc_pkg::CMD_WRITE_UPD) |  // RULE6
                             ((frame.cmd == dlurc_pkg::CMD_WRITE_IN) & ~strobe_lvl & ~mask_ch[ch])); // RULE3
            // copy of the held input contents
            assign copy    = (take & sel[ch] & (frame.cmd == dlurc_pkg::CMD_UPDATE)) |  // RULE5
                             (strobe_fall & ~mask_ch[ch]);                              // RULE4 RULE9 RULE11

            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    in_r[ch] <= ZERO_CODE;
                end else if (!run) begin
                    in_r[ch] <= por_code;                            // RULE13 RULE14
                end else if (wr_in) begin
                    in_r[ch] <= new_code;                            // RULE2
                end
            end

            // frame data wins over a strobe copy landing in the same cycle
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    dac_r[ch] <= ZERO_CODE;
                end else if (!run) begin
                    dac_r[ch] <= por_code;                           // RULE13 RULE14 RULE19
                end else if (now_upd) begin
                    dac_r[ch] <= new_code;
                end else if (copy) begin
                    dac_r[ch] <= in_r[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // load mask, cleared by any reset; address bits of its frame are ignored
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_r <= dlurc_pkg::LOAD_MASK_RST;
        end else if (!run) begin
            mask_r <= dlurc_pkg::LOAD_MASK_RST;                      // RULE8
        end else if (take && frame.cmd == dlurc_pkg::CMD_LOAD_MASK) begin
            mask_r <= frame.payload[3:0];                            // RULE7
        end
    end

    // reference setup bit, on after any reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ref_r <= dlurc_pkg::REF_SETUP_RST;
        end else if (!run) begin
            ref_r <= dlurc_pkg::REF_SETUP_RST;
        end else if (take && frame.cmd == dlurc_pkg::CMD_REF_SETUP) begin
            ref_r <= frame.payload[dlurc_pkg::REF_BIT];              // RULE20
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status flags: running and a pulse for a frame of wrong length
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            init_done_r <= 1'b0;
            reject_r    <= 1'b0;
        end else begin
            init_done_r <= (state_nxt == dlurc_pkg::ST_RUN);
            reject_r    <= frame_end & ~frame_ok;                    // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign o_dac_a         = dac_r[0];
    assign o_dac_b         = dac_r[1];
    assign o_input_a       = in_r[0];
    assign o_input_b       = in_r[1];
    assign o_load_mask     = mask_r;
    assign o_reference_off = ref_r;
    assign o_init_done     = init_done_r;
    assign o_frame_reject  = reject_r;

endmodule : dlurc_ctrl

// file: logic/dlurc_pkg.sv
// shared constants and carrier types of the dac load, update and reset control
package dlurc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // frame layout
    localparam int unsigned FRAME_BITS  = 24;            // serial clocks per frame
    localparam int unsigned CNT_W       = 5;             // frame bit counter width
    localparam logic [4:0]  FRAME_LEN   = 5'h18;         // 24 as counter value
    localparam logic [4:0]  CNT_SAT     = 5'h1f;         // counter stops here
    localparam int unsigned CMD_MSB     = 23;
    localparam int unsigned CMD_LSB     = 20;
    localparam int unsigned ADDR_MSB    = 19;
    localparam int unsigned ADDR_LSB    = 16;
    localparam int unsigned PAY_MSB     = 15;
    localparam int unsigned ADDR_A_BIT  = 0;             // within the address field
    localparam int unsigned ADDR_B_BIT  = 3;
    localparam int unsigned MASK_A_BIT  = 0;             // within the payload
    localparam int unsigned MASK_B_BIT  = 3;
    localparam int unsigned REF_BIT     = 0;

    ////////////////////////////////////////////////////////////////////////
    // commands
    localparam logic [3:0]  CMD_WRITE_IN  = 4'h1;
    localparam logic [3:0]  CMD_UPDATE    = 4'h2;
    localparam logic [3:0]  CMD_WRITE_UPD = 4'h3;
    localparam logic [3:0]  CMD_LOAD_MASK = 4'h5;
    localparam logic [3:0]  CMD_SOFT_RST  = 4'h6;
    localparam logic [3:0]  CMD_REF_SETUP = 4'h7;

    ////////////////////////////////////////////////////////////////////////
    // reset values and channel count
    localparam logic [3:0]  LOAD_MASK_RST = 4'h0;
    localparam logic        REF_SETUP_RST = 1'b0;        // reference on
    localparam int unsigned CHANNELS      = 2;

    ////////////////////////////////////////////////////////////////////////
    // carrier types
    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] payload;
    } dlurc_frame_s;

    typedef enum logic [2:0] {
        ST_WAIT  = 3'b001,
        ST_CLEAR = 3'b010,
        ST_RUN   = 3'b100
    } dlurc_state_e;

endpackage : dlurc_pkg

// file: logic/dlurc_sync3.sv
// three-stage synchroniser that passes a level once stages two and three agree
module dlurc_sync3 #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] ff1_r;
    logic [W-1:0] ff2_r;
    logic [W-1:0] ff3_r;

    if (W < 1) begin : g_bad_w
        $error("dlurc_sync3: W must be at least 1");
    end

    ////////////////////////////////////////////////////////////////////////
    // metastability chain; ff1 is read by ff2 only
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ff1_r <= RST_VAL;
            ff2_r <= RST_VAL;
            ff3_r <= RST_VAL;
        end else begin
            ff1_r <= i_async;
            ff2_r <= ff1_r;
            ff3_r <= ff2_r;
        end
    end

    // per bit, a change counts only when the two settled stages agree
    genvar b;
    generate
        for (b = 0; b < W; b++) begin : g_bit
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    o_level[b] <= RST_VAL[b];
                end else if (ff2_r[b] == ff3_r[b]) begin
                    o_level[b] <= ff3_r[b];
                end
            end
        end
    endgenerate

endmodule : dlurc_sync3

// file: logic/dlurc_frame_rx.sv
// serial-clock domain shift register and frame bit counter
module dlurc_frame_rx (
    input  wire logic                     i_sclk,
    input  wire logic                     i_rstn,
    input  wire logic                     i_sync_n,
    input  wire logic                     i_serial_in,
    output logic [dlurc_pkg::FRAME_BITS-1:0] o_shift,
    output logic [dlurc_pkg::CNT_W-1:0]   o_count
);
    logic armed_r;
    logic arm_clr;

    // frame sync high or reset re-arms the counter for the next frame
    assign arm_clr = ~i_rstn | i_sync_n;

    ////////////////////////////////////////////////////////////////////////
    // first falling edge of a frame restarts the count
    always_ff @(negedge i_sclk or posedge arm_clr) begin
        if (arm_clr) begin
            armed_r <= 1'b1;
        end else begin
            armed_r <= 1'b0;
        end
    end

    // shift and count only while sync is low; the word stays put after the frame
    // because the clock may stop, so the other domain reads it once sync is high
    always_ff @(negedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_shift <= '0;
            o_count <= '0;
        end else if (!i_sync_n) begin
            o_shift <= {o_shift[dlurc_pkg::FRAME_BITS-2:0], i_serial_in}; // RULE21
            if (armed_r) begin
                o_count <= 5'h01;
            end else if (o_count != dlurc_pkg::CNT_SAT) begin
                o_count <= o_count + 5'h01;                           // RULE1
            end
        end
    end

endmodule : dlurc_frame_rx

// file: dv/dlurc_assertions.sv
// concurrent checks on the ports of the dac load, update and reset control
module dlurc_assertions #(
    parameter int unsigned DATA_W = 10
) (
    input wire logic              i_clk,
    input wire logic              i_rstn,
    input wire logic              i_sclk,
    input wire logic              i_sync_n,
    input wire logic              i_serial_in,
    input wire logic              i_load_strobe_n,
    input wire logic              i_reset_n,
    input wire logic              i_reset_level_select,
    input wire logic [DATA_W-1:0] o_dac_a,
    input wire logic [DATA_W-1:0] o_dac_b,
    input wire logic [DATA_W-1:0] o_input_a,
    input wire logic [DATA_W-1:0] o_input_b,
    input wire logic [3:0]        o_load_mask,
    input wire logic              o_reference_off,
    input wire logic              o_init_done,
    input wire logic              o_frame_reject
);
    localparam logic [DATA_W-1:0] MID = {1'b1, {(DATA_W-1){1'b0}}};

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////////
    // eight cycles cover the pin synchroniser plus the forcing stage
    sequence s_pin_reset;
        (!i_reset_n)[*8];
    endsequence
    // strobe fall on unmasked channel a, held low long enough to be seen
    sequence s_strobe_fall_a;
        $fell(i_load_strobe_n) && o_init_done && !o_load_mask[0] && i_sync_n
        ##1 (!i_load_strobe_n && i_sync_n)[*4];
    endsequence

    ////////////////////////////////////////////////////////////////////////
    a_reject_pulse: assert property (o_frame_reject |=> !o_frame_reject)
        else $error("frame reject held longer than one cycle");
    a_reject_no_effect: assert property (o_frame_reject |-> $stable(o_dac_a) && $stable(o_dac_b))
        else $error("refused frame changed a dac register");
    a_reset_mid: assert property ((!i_reset_n && i_reset_level_select)[*8] |-> o_dac_a == MID && o_dac_b == MID)
        else $error("dac not at midscale during pin reset");
    a_reset_zero: assert property ((!i_reset_n && !i_reset_level_select)[*8] |-> o_dac_a == '0 && o_dac_b == '0)
        else $error("dac not at zero scale during pin reset");
    a_reset_regs: assert property (s_pin_reset |-> o_load_mask == 4'h0 && !o_reference_off && !o_init_done)
        else $error("mask, reference or init state wrong during pin reset");
    a_release_init: assert property ($rose(i_reset_n) ##1 i_reset_n[*8] |-> o_init_done)
        else $error("no initialisation after reset pin release");
    a_idle_stable: assert property ((i_sync_n && i_reset_n && i_load_strobe_n)[*8] |-> $stable(o_dac_a) && $stable(o_dac_b))
        else $error("dac changed with no frame, strobe or reset");
    a_masked_b: assert property ((i_sync_n && i_reset_n && o_load_mask[3])[*8] |-> $stable(o_dac_b))
        else $error("masked channel b followed the strobe");
    a_strobe_copy: assert property (s_strobe_fall_a |-> ##[1:4] (o_dac_a == o_input_a))
        else $error("strobe fall did not copy input a to dac a");
endmodule : dlurc_assertions

bind dlurc_ctrl dlurc_assertions #(.DATA_W(DATA_W)) u_chk (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_sclk(i_sclk), .i_sync_n(i_sync_n), .i_serial_in(i_serial_in),
    .i_load_strobe_n(i_load_strobe_n), .i_reset_n(i_reset_n), .i_reset_level_select(i_reset_level_select),
    .o_dac_a(o_dac_a), .o_dac_b(o_dac_b), .o_input_a(o_input_a), .o_input_b(o_input_b),
    .o_load_mask(o_load_mask), .o_reference_off(o_reference_off), .o_init_done(o_init_done),
    .o_frame_reject(o_frame_reject)
);

// file: dv/dlurc_host_model.sv
// host side model: frames on the serial link with a gated 48 ns link clock
module dlurc_host_model (
    output logic o_sclk,
    output logic o_sync_n,
    output logic o_serial_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // link clock idles high and stands still between frames
    initial begin
        o_sclk      = 1'b1;
        o_sync_n    = 1'b1;
        o_serial_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one frame msb first; a count other than 24 makes a deliberately bad frame
    task automatic send(input logic [23:0] f, input int n);
        #7;
        o_sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            o_serial_in = f[23 - (i % 24)];
            #24 o_sclk = 1'b0;
            #24 o_sclk = 1'b1;
        end
        #24 o_sync_n = 1'b1;
        // released data line shows the inverse so a stale bit never looks valid
        o_serial_in = ~o_serial_in;
    endtask : send
endmodule : dlurc_host_model

// file: dv/tb.sv
// self-checking bench for the dac load, update and reset control
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned DW = 10;
    logic          clk = 1'b0, rstn = 1'b0, strobe_n = 1'b1, reset_n = 1'b0, sel = 1'b1;
    logic          sclk, sync_n, serial_in, ref_off, init_done, rej, rej_seen;
    logic [DW-1:0] dac_a, dac_b, in_a, in_b;
    logic [3:0]    mask;
    int            fail_count = 0;
    int            samples_checked = 0;

    always #12.5 clk = ~clk;

    dlurc_host_model host (.o_sclk(sclk), .o_sync_n(sync_n), .o_serial_in(serial_in));
    dlurc_ctrl #(.DATA_W(DW)) uut (
        .i_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_sync_n(sync_n), .i_serial_in(serial_in),
        .i_load_strobe_n(strobe_n), .i_reset_n(reset_n), .i_reset_level_select(sel),
        .o_dac_a(dac_a), .o_dac_b(dac_b), .o_input_a(in_a), .o_input_b(in_b), .o_load_mask(mask),
        .o_reference_off(ref_off), .o_init_done(init_done), .o_frame_reject(rej)
    );

    // sticky record of a one-cycle refusal pulse, cleared by the sequence
    always @(posedge clk) if (rej === 1'b1) rej_seen <= 1'b1;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    // twelve clocks cover the sync crossing plus the register update
    task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] p, input int n = 24);
        host.send({c, a, p}, n);
        repeat (12) @(negedge clk);
    endtask : frame
    task automatic wr(input logic [3:0] c, input logic [3:0] a, input logic [DW-1:0] d);
        frame(c, a, {d, 6'h00});
    endtask : wr
    task automatic strobe_pulse;
        strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        strobe_n = 1'b1;
        repeat (8) @(negedge clk);
    endtask : strobe_pulse
    task automatic wait_init;
        for (int i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge clk);
        check("init_done", init_done, 16'h0001);
    endtask : wait_init
    task automatic dacs(input string t, input logic [DW-1:0] a, input logic [DW-1:0] b);
        check({t, " dac_a"}, dac_a, a);
        check({t, " dac_b"}, dac_b, b);
        $display("test %s done", t);
    endtask : dacs

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs about 30 us
    initial begin
        #200us;
        fail_count++;
        $display("watchdog expired");
        end_of_test;
    end

    initial begin
        rej_seen = 1'b0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        // reset pin held through power-up: waiting, strobe ignored
        strobe_pulse;
        check("init low", init_done, 16'h0000);
        dacs("power-up", 10'h200, 10'h200);
        check("mask rst", mask, 16'h0000);
        check("ref rst", ref_off, 16'h0000);
        reset_n = 1'b1;
        wait_init;
        dacs("por hold", 10'h200, 10'h200);
        wr(4'h3, 4'h1, 10'h155);
        dacs("write update", 10'h155, 10'h200);
        check("in_a", in_a, 16'h0155);
        // deferred update of b, then the strobe copies it
        wr(4'h1, 4'h8, 10'h2aa);
        check("in_b", in_b, 16'h02aa);
        dacs("deferred", 10'h155, 10'h200);
        strobe_pulse;
        dacs("strobe", 10'h155, 10'h2aa);
        // mask b; address bits carry junk
        frame(4'h5, 4'hf, 16'h0008);
        check("mask", mask, 16'h0008);
        wr(4'h1, 4'h1, 10'h0f0);
        wr(4'h1, 4'h8, 10'h30f);
        strobe_pulse;
        dacs("masked strobe", 10'h0f0, 10'h2aa);
        // strobe held low: a updates at once, masked b sees it high
        strobe_n = 1'b0;
        repeat (8) @(negedge clk);
        wr(4'h1, 4'h1, 10'h222);
        wr(4'h1, 4'h8, 10'h111);
        dacs("strobe low", 10'h222, 10'h2aa);
        strobe_n = 1'b1;
        repeat (8) @(negedge clk);
        // update of b only, inputs untouched
        wr(4'h1, 4'h1, 10'h3c3);
        wr(4'h2, 4'h8, 10'h3ff);
        dacs("update cmd", 10'h222, 10'h111);
        check("in_b upd", in_b, 16'h0111);
        // short and long frames are refused
        rej_seen = 1'b0;
        frame(4'h3, 4'h1, 16'hffc0, 23);
        check("reject 23", rej_seen, 16'h0001);
        rej_seen = 1'b0;
        frame(4'h3, 4'h1, 16'hffc0, 25);
        check("reject 25", rej_seen, 16'h0001);
        dacs("refused", 10'h222, 10'h111);
        frame(4'h7, 4'h0, 16'h0001);
        check("ref off", ref_off, 16'h0001);
        frame(4'h7, 4'h0, 16'h0000);
        check("ref on", ref_off, 16'h0000);
        frame(4'h7, 4'h0, 16'h0001);
        frame(4'h6, 4'h0, 16'h0000);
        dacs("soft reset", 10'h200, 10'h200);
        check("soft mask", mask, 16'h0000);
        check("soft ref", ref_off, 16'h0000);
        // pin reset to zero scale; writes and strobe blocked meanwhile
        wr(4'h3, 4'h9, 10'h3ff);
        sel = 1'b0;
        repeat (8) @(negedge clk);
        reset_n = 1'b0;
        repeat (10) @(negedge clk);
        dacs("pin reset", 10'h000, 10'h000);
        wr(4'h3, 4'h9, 10'h155);
        strobe_pulse;
        dacs("blocked", 10'h000, 10'h000);
        reset_n = 1'b1;
        wait_init;
        dacs("cleared", 10'h000, 10'h000);
        // strobe tied low from reset: mask is disregarded
        strobe_n = 1'b0;
        rstn = 1'b0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        wait_init;
        frame(4'h5, 4'h0, 16'h0009);
        wr(4'h1, 4'h9, 10'h2cd);
        dacs("tied low", 10'h2cd, 10'h2cd);
        end_of_test;
    end
endmodule : tb
